/* File: shared/lcd_pkg.sv */
package lcd_pkg;
   // --------------------------------------------------------------------
   // Command opcodes (upper nibble) and special bytes.
   // --------------------------------------------------------------------
   localparam logic [3:0] OP_HOME     = 4'h1;
   localparam logic [3:0] OP_DISPLAY  = 4'h3;
   localparam logic [3:0] OP_PWR_SAVE = 4'h4;
   localparam logic [3:0] OP_PWR_CTRL = 4'h5;
   localparam logic [3:0] OP_SYS_SET  = 4'h6;
   localparam logic [3:0] OP_CONTRAST = 4'h7;
   localparam logic [7:0] CMD_NOP     = 8'h00;
   localparam logic [7:0] CMD_TEST    = 8'h0A;
   localparam int         ADDR_SET_BIT = 7;

   // --------------------------------------------------------------------
   // Field positions.
   // --------------------------------------------------------------------
   localparam int DC_CURSOR_BIT = 3;
   localparam int DC_BLINK_BIT  = 2;
   localparam int DC_TWIN_BIT   = 1;
   localparam int DC_DISP_BIT   = 0;
   localparam int PS_OSC_BIT    = 1;
   localparam int PS_SLEEP_BIT  = 0;
   localparam int PC_RSVD_BIT   = 3;
   localparam int PC_REG_BIT    = 2;
   localparam int PC_FOL_BIT    = 1;
   localparam int PC_BOOST_BIT  = 0;
   localparam int SS_LINE_HI_BIT = 3;
   localparam int SS_LINE_LO_BIT = 2;
   localparam int SS_GLYPH_BIT  = 0;

   // --------------------------------------------------------------------
   // Reset values, sizes and timing.
   // --------------------------------------------------------------------
   localparam logic [6:0] HOME_ADDR      = 7'h30;
   localparam logic [6:0] ADDR_RESET     = 7'h00;
   localparam logic [3:0] CONTRAST_RESET = 4'h0;
   localparam logic [1:0] LINES_RESET    = 2'h0;
   localparam int         MEM_DEPTH      = 128;
   localparam int         CLK_KHZ        = 25000;
   localparam int         INIT_NS        = 1000;
   localparam int         INIT_CYCLES    = (INIT_NS * CLK_KHZ) / 1000000;
   localparam int         RESET_HOLD_NS  = 10000;
   localparam int         RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_KHZ + 999999) / 1000000;
   localparam int         BLINK_MS       = 1000;
   localparam int         BLINK_CYCLES   = BLINK_MS * (CLK_KHZ / 2);
   localparam int         GAP_CYCLES     = 4;
endpackage : lcd_pkg

/* File: shared/lcd_bus_if.sv */
`timescale 1ns/100ps
interface lcd_bus_if;
   logic       chip_reset_in;
   logic       wr_stb;
   logic       register_select;
   logic [7:0] data;
   logic       ready;

   modport device (input chip_reset_in, input wr_stb, input register_select, input data,
                   output ready);
   modport host   (output chip_reset_in, output wr_stb, output register_select, output data,
                   input ready);
endinterface : lcd_bus_if

/* File: design/lcd_device.sv */
`timescale 1ns/100ps
module lcd_device
   import lcd_pkg::*;
#(
   parameter int INIT_CYC  = INIT_CYCLES,
   parameter int BLINK_CYC = BLINK_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   lcd_bus_if.device       bus,
   input  wire logic [6:0] rd_addr,
   output logic      [7:0] rd_data_ff,
   output logic      [6:0] addr_ff,
   output logic            cursor_on_ff,
   output logic            blink_on_ff,
   output logic            twin_cursor_ff,
   output logic            display_on_ff,
   output logic            osc_on_ff,
   output logic            sleep_req_ff,
   output logic            regulator_on_ff,
   output logic            follower_on_ff,
   output logic            booster_on_ff,
   output logic      [1:0] line_count_ff,
   output logic            user_glyph_sel_ff,
   output logic      [3:0] contrast_ff,
   output logic            drive_high_ff,
   output logic            cursor_reverse_ff,
   output logic            standby_ff
);
   // --------------------------------------------------------------------
   // Input synchronisers and reset hold-off.
   // --------------------------------------------------------------------
   logic        rst_s1_ff;
   logic        rst_s2_ff;
   logic        wr_s1_ff;
   logic        wr_s2_ff;
   logic        wr_s3_ff;
   logic        rs_s1_ff;
   logic        rs_s2_ff;
   logic [7:0]  dat_s1_ff;
   logic [7:0]  dat_s2_ff;
   logic [15:0] init_cnt_ff;
   logic        run_ff;
   logic        take;
   logic [3:0]  op;
   logic [3:0]  arg;
   logic        is_cmd;
   logic [7:0]  mem [MEM_DEPTH];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
         wr_s1_ff  <= 1'b0;
         wr_s2_ff  <= 1'b0;
         wr_s3_ff  <= 1'b0;
         rs_s1_ff  <= 1'b0;
         rs_s2_ff  <= 1'b0;
         dat_s1_ff <= 8'h00;
         dat_s2_ff <= 8'h00;
      end else begin
         rst_s1_ff <= bus.chip_reset_in;
         rst_s2_ff <= rst_s1_ff;
         wr_s1_ff  <= bus.wr_stb;
         wr_s2_ff  <= wr_s1_ff;
         wr_s3_ff  <= wr_s2_ff;
         rs_s1_ff  <= bus.register_select;
         rs_s2_ff  <= rs_s1_ff;
         dat_s1_ff <= bus.data;
         dat_s2_ff <= dat_s1_ff;
      end
   end

   // Soft reset input and the hold-off count before commands are taken.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         init_cnt_ff <= 16'h0000;
         run_ff      <= 1'b0;
      end else if (rst_s2_ff) begin
         init_cnt_ff <= 16'h0000;
         run_ff      <= 1'b0;
      end else if (!run_ff) begin
         init_cnt_ff <= init_cnt_ff + 16'h0001;
         run_ff      <= (init_cnt_ff >= 16'(INIT_CYC - 1));
      end
   end

   assign take   = run_ff && !rst_s2_ff && wr_s2_ff && !wr_s3_ff;
   assign is_cmd = !rs_s2_ff;
   assign op     = dat_s2_ff[7:4];
   assign arg    = dat_s2_ff[3:0];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.ready <= 1'b0;
      end else begin
         bus.ready <= run_ff && !rst_s2_ff;
      end
   end

   // --------------------------------------------------------------------
   // Control registers.
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cursor_on_ff   <= 1'b0;
         blink_on_ff    <= 1'b0;
         twin_cursor_ff <= 1'b0;
         display_on_ff  <= 1'b0;
      end else if (rst_s2_ff) begin
         cursor_on_ff   <= 1'b0;
         blink_on_ff    <= 1'b0;
         twin_cursor_ff <= 1'b0;
         display_on_ff  <= 1'b0;
      end else if (take && is_cmd && !dat_s2_ff[ADDR_SET_BIT] && op == OP_DISPLAY) begin
         cursor_on_ff   <= arg[DC_CURSOR_BIT];
         blink_on_ff    <= arg[DC_BLINK_BIT];
         twin_cursor_ff <= arg[DC_TWIN_BIT];
         display_on_ff  <= arg[DC_DISP_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_on_ff    <= 1'b0;
         sleep_req_ff <= 1'b0;
      end else if (rst_s2_ff) begin
         osc_on_ff    <= 1'b0;
         sleep_req_ff <= 1'b0;
      end else if (take && is_cmd && !dat_s2_ff[ADDR_SET_BIT] && op == OP_PWR_SAVE) begin
         osc_on_ff    <= arg[PS_OSC_BIT];
         sleep_req_ff <= arg[PS_SLEEP_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regulator_on_ff <= 1'b0;
         follower_on_ff  <= 1'b0;
         booster_on_ff   <= 1'b0;
      end else if (rst_s2_ff) begin
         regulator_on_ff <= 1'b0;
         follower_on_ff  <= 1'b0;
         booster_on_ff   <= 1'b0;
      end else if (take && is_cmd && !dat_s2_ff[ADDR_SET_BIT] && op == OP_PWR_CTRL
                   && !arg[PC_RSVD_BIT]) begin
         regulator_on_ff <= arg[PC_REG_BIT];
         follower_on_ff  <= arg[PC_FOL_BIT];
         booster_on_ff   <= arg[PC_BOOST_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_count_ff     <= LINES_RESET;
         user_glyph_sel_ff <= 1'b0;
      end else if (rst_s2_ff) begin
         user_glyph_sel_ff <= 1'b0;
      end else if (take && is_cmd && !dat_s2_ff[ADDR_SET_BIT] && op == OP_SYS_SET) begin
         line_count_ff     <= {arg[SS_LINE_HI_BIT], arg[SS_LINE_LO_BIT]};
         user_glyph_sel_ff <= arg[SS_GLYPH_BIT];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         contrast_ff <= CONTRAST_RESET;
      end else if (rst_s2_ff) begin
         contrast_ff <= CONTRAST_RESET;
      end else if (take && is_cmd && !dat_s2_ff[ADDR_SET_BIT] && op == OP_CONTRAST) begin
         contrast_ff <= arg;
      end
   end

   // --------------------------------------------------------------------
   // Address counter and memory. Other bytes (NOP, test) touch nothing.
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_ff <= ADDR_RESET;
      end else if (take && is_cmd && dat_s2_ff[ADDR_SET_BIT]) begin
         addr_ff <= dat_s2_ff[6:0];
      end else if (take && is_cmd && op == OP_HOME) begin
         addr_ff <= HOME_ADDR;
      end else if (take && !is_cmd) begin
         addr_ff <= addr_ff + 7'h01;
      end
   end

   // Memory is never cleared, so sleep and reset keep its contents.
   always_ff @(posedge clk) begin
      if (take && !is_cmd) begin
         mem[addr_ff] <= dat_s2_ff;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= mem[rd_addr];
      end
   end

   // --------------------------------------------------------------------
   // Output drive, cursor video and standby state.
   // --------------------------------------------------------------------
   logic [31:0] blink_cnt_ff;
   logic        blink_phase_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         blink_cnt_ff   <= 32'h00000000;
         blink_phase_ff <= 1'b0;
      end else if (!osc_on_ff || blink_cnt_ff >= 32'(BLINK_CYC - 1)) begin
         blink_cnt_ff   <= 32'h00000000;
         blink_phase_ff <= osc_on_ff && !blink_phase_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 32'h00000001;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_high_ff     <= 1'b0;
         cursor_reverse_ff <= 1'b0;
         standby_ff        <= 1'b0;
      end else begin
         drive_high_ff     <= sleep_req_ff;
         cursor_reverse_ff <= cursor_on_ff && (!blink_on_ff || blink_phase_ff);
         standby_ff        <= osc_on_ff && !regulator_on_ff && !follower_on_ff
                              && !booster_on_ff;
      end
   end
endmodule : lcd_device

/* File: design/lcd_host.sv */
`timescale 1ns/100ps
module lcd_host
   import lcd_pkg::*;
#(
   parameter int HOLD_CYC = RESET_HOLD_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   lcd_bus_if.host         bus,
   input  wire logic       cmd_valid,
   input  wire logic       cmd_is_data,
   input  wire logic [7:0] cmd_byte,
   input  wire logic       soft_reset,
   output logic            busy_ff
);
   // --------------------------------------------------------------------
   // Reset pulse, spaced writes, test byte filtered.
   // --------------------------------------------------------------------
   logic [15:0] hold_ff;
   logic [3:0]  gap_ff;
   logic        ready_s1_ff;
   logic        ready_s2_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ready_s1_ff <= 1'b0;
         ready_s2_ff <= 1'b0;
      end else begin
         ready_s1_ff <= bus.ready;
         ready_s2_ff <= ready_s1_ff;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_ff           <= 16'(HOLD_CYC);
         bus.chip_reset_in <= 1'b1;
      end else if (soft_reset) begin
         hold_ff           <= 16'(HOLD_CYC);
         bus.chip_reset_in <= 1'b1;
      end else if (hold_ff != 16'h0000) begin
         hold_ff <= hold_ff - 16'h0001;
      end else begin
         bus.chip_reset_in <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_ff              <= 4'h0;
         bus.wr_stb          <= 1'b0;
         bus.register_select <= 1'b0;
         bus.data            <= 8'h00;
      end else if (gap_ff != 4'h0) begin
         gap_ff     <= gap_ff - 4'h1;
         bus.wr_stb <= (gap_ff > 4'(GAP_CYCLES / 2));
      end else if (cmd_valid && !bus.chip_reset_in && ready_s2_ff
                   && !(!cmd_is_data && cmd_byte == CMD_TEST)) begin
         gap_ff              <= 4'(GAP_CYCLES * 2);
         bus.wr_stb          <= 1'b1;
         bus.register_select <= cmd_is_data;
         bus.data            <= cmd_byte;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_ff <= 1'b1;
      end else begin
         busy_ff <= bus.chip_reset_in || !ready_s2_ff || gap_ff > 4'h1;
      end
   end
endmodule : lcd_host

/* File: verif/lcd_bus_assertions.sv */
`timescale 1ns/100ps
module lcd_bus_assertions #(
   parameter int HOLD_CYC = 250,
   parameter int INIT_CYC = 25
) (
   input logic       clk,
   input logic       reset_n,
   input logic       chip_reset_in,
   input logic       wr_stb,
   input logic       register_select,
   input logic [7:0] data,
   input logic       ready
);
   // ------------------------------------------------------------------
   // Cycle counters for the reset pulse and the start-up wait.
   // ------------------------------------------------------------------
   logic [15:0] hold_cnt_ff;
   logic [15:0] init_cnt_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_cnt_ff <= '0;
      end else if (chip_reset_in) begin
         hold_cnt_ff <= hold_cnt_ff + 16'h1;
      end else begin
         hold_cnt_ff <= '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         init_cnt_ff <= '0;
      end else if (chip_reset_in) begin
         init_cnt_ff <= '0;
      end else if (!ready) begin
         init_cnt_ff <= init_cnt_ff + 16'h1;
      end
   end

   // ------------------------------------------------------------------
   // Bus checks.
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_strobe_width: assert property ($rose(wr_stb) |-> wr_stb [*7] ##1 !wr_stb)
      else $error("write strobe width wrong");
   a_strobe_gap: assert property ($fell(wr_stb) |-> !wr_stb [*2])
      else $error("write strobe gap too short");
   a_bus_stable: assert property (wr_stb && $past(wr_stb) |-> $stable(data) && $stable(register_select))
      else $error("bus changed during strobe");
   a_write_ready: assert property ($rose(wr_stb) |-> ready && !chip_reset_in)
      else $error("write while device not ready");
   a_no_test: assert property (wr_stb && !register_select |-> data != 8'h0A)
      else $error("reserved test byte sent");
   a_reset_hold: assert property ($fell(chip_reset_in) |-> hold_cnt_ff >= HOLD_CYC - 1)
      else $error("reset pulse too short");
   a_ready_low: assert property (chip_reset_in [*4] |-> !ready)
      else $error("ready during reset");
   a_init_time: assert property ($rose(ready) |-> init_cnt_ff >= INIT_CYC - 1 && init_cnt_ff <= INIT_CYC + 6)
      else $error("start-up time wrong");
endmodule : lcd_bus_assertions

/* File: verif/tb_lcd_command_decoder.sv */
`timescale 1ns/100ps
module tb_lcd_command_decoder;
   import lcd_pkg::*;
   logic       clk, reset_n, cmd_valid, cmd_is_data, soft_reset, busy_ff;
   logic [7:0] cmd_byte, rd_data_ff;
   logic [6:0] rd_addr, addr_ff;
   logic       cursor_on_ff, blink_on_ff, twin_cursor_ff, display_on_ff, osc_on_ff;
   logic       sleep_req_ff, regulator_on_ff, follower_on_ff, booster_on_ff, user_glyph_sel_ff;
   logic       drive_high_ff, cursor_reverse_ff, standby_ff, s0, s1;
   logic [1:0] line_count_ff;
   logic [3:0] contrast_ff;
   logic [31:0] r;
   bit         m_cur, m_blk, m_twn, m_dsp, m_osc, m_slp, m_reg, m_fol, m_bst, m_gly;
   int         m_lines, m_con, m_adr, n_errors, tests_run, seed;
   int         mem [128];
   int         wq [$];
   logic [7:0] tbl [$] = '{8'h60, 8'h3F, 8'h35, 8'h3B, 8'h42, 8'h57, 8'h5F, 8'h52, 8'h50, 8'h41,
                           8'h40, 8'h69, 8'h65, 8'h7A, 8'h70, 8'h00, 8'h0A, 8'h1C, 8'h2F, 8'hFE};

   lcd_bus_if bus_if ();
   lcd_host #(.HOLD_CYC(20)) lcd_host_inst (.clk, .reset_n, .bus(bus_if), .cmd_valid,
      .cmd_is_data, .cmd_byte, .soft_reset, .busy_ff);
   lcd_device #(.INIT_CYC(5), .BLINK_CYC(4)) lcd_device_inst (.clk, .reset_n, .bus(bus_if),
      .rd_addr, .rd_data_ff, .addr_ff, .cursor_on_ff, .blink_on_ff, .twin_cursor_ff,
      .display_on_ff, .osc_on_ff, .sleep_req_ff, .regulator_on_ff, .follower_on_ff,
      .booster_on_ff, .line_count_ff, .user_glyph_sel_ff, .contrast_ff, .drive_high_ff,
      .cursor_reverse_ff, .standby_ff);
   lcd_bus_assertions #(.HOLD_CYC(20), .INIT_CYC(5)) lcd_bus_assertions_inst (.clk, .reset_n,
      .chip_reset_in(bus_if.chip_reset_in), .wr_stb(bus_if.wr_stb),
      .register_select(bus_if.register_select), .data(bus_if.data), .ready(bus_if.ready));

   // ------------------------------------------------------------------
   // Tasks.
   // ------------------------------------------------------------------
   task summarize;
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task chk_ctl(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_ctl

   task chk_mem(input int a, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected memory byte %0d: expected %h, seen %h", a, exp, got);
      end
   endtask : chk_mem

   task check_all;
      chk_ctl("flags", {m_cur, m_blk, m_twn, m_dsp, m_osc, m_slp, m_reg, m_fol, m_bst, m_gly,
         2'(m_lines)}, {cursor_on_ff, blink_on_ff, twin_cursor_ff, display_on_ff, osc_on_ff,
         sleep_req_ff, regulator_on_ff, follower_on_ff, booster_on_ff, user_glyph_sel_ff,
         line_count_ff});
      chk_ctl("address", 16'(m_adr), 16'(addr_ff));
      chk_ctl("contrast", 16'(m_con), 16'(contrast_ff));
      chk_ctl("drive high", 16'(m_slp), 16'(drive_high_ff));
      chk_ctl("standby", 16'(m_osc & !m_reg & !m_fol & !m_bst), 16'(standby_ff));
      if (!m_cur || !m_blk) begin
         chk_ctl("cursor reverse", 16'(m_cur), 16'(cursor_reverse_ff));
      end
   endtask : check_all

   task wait_idle;
      int k;
      k = 0;
      @(negedge clk);
      while ((busy_ff !== 1'b0 || bus_if.ready !== 1'b1) && k < 600) begin
         @(negedge clk);
         k++;
      end
      if (k >= 600) begin
         n_errors++;
         summarize();
      end
   endtask : wait_idle

   task send(input bit d, input logic [7:0] b);
      wait_idle();
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_is_data <= d;
      cmd_byte <= b;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (4) @(posedge clk);
      wait_idle();
      if (d) begin
         mem[m_adr] = b;
         wq.push_back(m_adr);
         m_adr = (m_adr + 1) % 128;
      end else if (b[7]) begin
         m_adr = b[6:0];
      end else begin
         case (b[7:4])
            OP_HOME: m_adr = HOME_ADDR;
            OP_DISPLAY: {m_cur, m_blk, m_twn, m_dsp} = b[3:0];
            OP_PWR_SAVE: {m_osc, m_slp} = b[1:0];
            OP_PWR_CTRL: if (!b[3]) {m_reg, m_fol, m_bst} = b[2:0];
            OP_SYS_SET: {m_lines, m_gly} = {b[3:2], b[0]};
            OP_CONTRAST: m_con = b[3:0];
            default: ;
         endcase
      end
      check_all();
   endtask : send

   task check_mem;
      foreach (wq[j]) begin
         @(posedge clk);
         rd_addr <= 7'(wq[j]);
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk_mem(wq[j], 8'(mem[wq[j]]), rd_data_ff);
      end
   endtask : check_mem

   // ------------------------------------------------------------------
   // Clock, watchdog and main sequence.
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      #(40 * 30000);
      n_errors++;
      summarize();
   end

   initial begin
      {reset_n, cmd_valid, cmd_is_data, soft_reset, cmd_byte, rd_addr} = '0;
      seed = 25;
      repeat (15) @(posedge clk);
      @(negedge clk);
      check_all();
      @(posedge clk);
      reset_n <= 1'b1;
      wait_idle();
      check_all();
      foreach (tbl[j]) send(1'b0, tbl[j]);
      repeat (4) send(1'b1, 8'($random(seed)));
      check_mem();
      send(1'b0, 8'h41);
      send(1'b0, 8'h42);
      check_mem();
      send(1'b0, 8'h3F);
      {s0, s1} = 2'b00;
      repeat (24) begin
         @(negedge clk);
         s0 = s0 | (cursor_reverse_ff === 1'b0);
         s1 = s1 | (cursor_reverse_ff === 1'b1);
      end
      chk_ctl("blink alternation", 16'h3, 16'({s0, s1}));
      repeat (40) begin
         r = $random(seed);
         if (r[7:2] == 6'b011011) r[3] = 1'b0;
         if (!r[8] && r[7:4] == OP_PWR_CTRL && !m_osc) r[0] = 1'b0;
         if (!r[8] && r[7:4] == OP_PWR_SAVE && (m_reg || m_fol || m_bst)) r[1:0] = 2'b10;
         send(r[8], r[7:0]);
      end
      check_mem();
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      repeat (4) @(posedge clk);
      wait_idle();
      {m_cur, m_blk, m_twn, m_dsp, m_osc, m_slp, m_reg, m_fol, m_bst, m_gly} = '0;
      m_con = 0;
      check_all();
      check_mem();
      summarize();
   end
endmodule : tb_lcd_command_decoder
